/* verilog/lmx_map.vh */
// What this block does
// - Write strobe rise shifts data bit in
// - Read strobe fall presents next RAM bit
// - Chip select high refuses access, resets interface
// - Transfers only while chip select is low
// - Internal lead: RC clock, driven on pin
// - Follower or external lead: clock from pin
// - Lead modes drive frame sync pin out
// - Follower mode takes frame sync as input
// - Display RAM of 88 four-bit words
// - Sixteen-level PWM brightness control
// - Scan 44 rows against 8 commons
// - Internal oscillator runs at 256 kHz
// - Two-wire variant: pins become address inputs
// - Command and data instruction categories
// - One frame per 2624 system clocks
`ifndef LMX_MAP_VH
`define LMX_MAP_VH
// Core clock and oscillator rates in kHz
`define LMX_CLK_FREQ_KHZ  200000
`define LMX_RC_FREQ_KHZ   256
// Half period of the internal oscillator, rounded down
`define LMX_RC_HALF_CYC   (`LMX_CLK_FREQ_KHZ / (2 * `LMX_RC_FREQ_KHZ))
// Display geometry
`define LMX_RAM_WORDS     88
`define LMX_ROWS          44
`define LMX_COMS          8
// Scan timing in system clock periods
`define LMX_FRAME_TICKS   2624
`define LMX_SLOT_TICKS    (`LMX_FRAME_TICKS / `LMX_COMS)
`define LMX_PWM_STEP      20
// Instruction identifiers, three bits
`define LMX_ID_CMD        3'h4
`define LMX_ID_WRITE      3'h5
`define LMX_ID_READ       3'h6
// Command bytes
`define LMX_CMD_FOLLOW    8'h10
`define LMX_CMD_INT_LEAD  8'h18
`define LMX_CMD_EXT_LEAD  8'h1C
`define LMX_CMD_BRIGHT    4'hA
// Field widths
`define LMX_ADDR_W        7
`define LMX_NIB_W         4
`define LMX_FIFO_DEPTH    16
`endif

/* verilog/lmx_fifo.v */
`timescale 1ns/1ps
`default_nettype none
module lmx_fifo #(
  parameter WIDTH = 11,
  parameter DEPTH = 16,
  parameter AW    = 4
) (
  input  wire             clk_in,
  input  wire             nrst_in,
  input  wire             flush_in,
  input  wire [WIDTH-1:0] wr_data_in,
  input  wire             wr_valid_in,
  output wire             wr_ready_out,
  output wire [WIDTH-1:0] rd_data_out,
  output wire             rd_valid_out,
  input  wire             rd_ready_in
);
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW:0]      wr_ptr_reg;
  reg [AW:0]      rd_ptr_reg;
  wire            full;
  wire            empty;
  wire            push;
  wire            pop;

  // Extra pointer bit tells full from empty
  assign full         = (wr_ptr_reg[AW] != rd_ptr_reg[AW]) &&
                        (wr_ptr_reg[AW-1:0] == rd_ptr_reg[AW-1:0]);
  assign empty        = (wr_ptr_reg == rd_ptr_reg);
  assign wr_ready_out = ~full;
  assign rd_valid_out = ~empty;
  assign rd_data_out  = mem[rd_ptr_reg[AW-1:0]];
  assign push         = wr_valid_in & ~full;
  assign pop          = rd_ready_in & ~empty;

  // Storage is written without reset, pointers define contents
  always @(posedge clk_in)
  begin
    if (push)
      mem[wr_ptr_reg[AW-1:0]] <= wr_data_in;
  end

  // Pointer update
  always @(posedge clk_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      wr_ptr_reg <= {(AW+1){1'b0}};
      rd_ptr_reg <= {(AW+1){1'b0}};
    end
    else if (flush_in)
    begin
      wr_ptr_reg <= {(AW+1){1'b0}};
      rd_ptr_reg <= {(AW+1){1'b0}};
    end
    else
    begin
      if (push)
        wr_ptr_reg <= wr_ptr_reg + {{AW{1'b0}}, 1'b1};
      if (pop)
        rd_ptr_reg <= rd_ptr_reg + {{AW{1'b0}}, 1'b1};
    end
  end
endmodule
`default_nettype wire

/* verilog/lmx_core.v */
`timescale 1ns/1ps
`default_nettype none
`include "lmx_map.vh"
module lmx_core #(
  parameter [2:0] RESET_MODE = 3'h2
) (
  input  wire        clk_in,
  input  wire        nrst_in,
  input  wire        two_wire_variant_in,
  input  wire        chip_select_n_in,
  input  wire        write_strobe_clock_in,
  input  wire        read_strobe_clock_in,
  input  wire        data_in,
  output reg         data_out,
  output reg         data_oe_out,
  input  wire        osc_in,
  output reg         osc_out,
  output reg         osc_oe_out,
  input  wire        sync_in,
  output reg         sync_out,
  output reg         sync_oe_out,
  output reg  [1:0]  bus_addr_out,
  output reg  [2:0]  clock_mode_out,
  output reg  [7:0]  shared_scan_lines_out,
  output reg  [43:0] segment_drive_lines_out
);
  // Clock modes, one-hot
  localparam [2:0] MODE_FOLLOW   = 3'h1;
  localparam [2:0] MODE_INT_LEAD = 3'h2;
  localparam [2:0] MODE_EXT_LEAD = 3'h4;
  // Serial states, one-hot
  localparam [4:0] ST_ID    = 5'h01;
  localparam [4:0] ST_CMD   = 5'h02;
  localparam [4:0] ST_ADDR  = 5'h04;
  localparam [4:0] ST_WDATA = 5'h08;
  localparam [4:0] ST_RDATA = 5'h10;

  // Next address with wrap at the end of RAM
  function [6:0] lmx_next_addr;
    input [6:0] a;
    begin
      if (a == 7'd87)
        lmx_next_addr = 7'h00;
      else
        lmx_next_addr = a + 7'h01;
    end
  endfunction

  // Pin synchronisers, second stage feeds all logic
  reg [5:0] sync1_reg;
  reg [5:0] sync2_reg;
  reg [5:0] sync3_reg;
  wire cs_n    = sync2_reg[0];
  wire wr_clk  = sync2_reg[1];
  wire rd_clk  = sync2_reg[2];
  wire din     = sync2_reg[3];
  wire osc_pin = sync2_reg[4];
  wire sync_pin = sync2_reg[5];
  wire wr_rise = wr_clk & ~sync3_reg[1];
  wire rd_fall = ~rd_clk & sync3_reg[2];
  wire osc_rise = osc_pin & ~sync3_reg[4];
  wire sync_rise = sync_pin & ~sync3_reg[5];

  always @(posedge clk_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      sync1_reg <= 6'h3F;
      sync2_reg <= 6'h3F;
      sync3_reg <= 6'h3F;
    end
    else
    begin
      sync1_reg <= {sync_in, osc_in, data_in, read_strobe_clock_in,
                    write_strobe_clock_in, chip_select_n_in};
      sync2_reg <= sync1_reg;
      sync3_reg <= sync2_reg;
    end
  end

  // Variant strap caught after reset release, never in the reset branch
  reg strap_done_reg;
  reg two_wire_reg;
  always @(posedge clk_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      strap_done_reg <= 1'b0;
      two_wire_reg   <= 1'b0;
      bus_addr_out   <= 2'h0;
    end
    else
    begin
      if (!strap_done_reg)
      begin
        strap_done_reg <= 1'b1;
        two_wire_reg   <= two_wire_variant_in;
      end
      if (two_wire_reg)
        bus_addr_out <= {rd_clk, cs_n};
    end
  end

  // Display RAM and the settings it is shown with
  reg [3:0] ram [0:`LMX_RAM_WORDS-1];
  reg [3:0] bright_reg;
  wire serial_en = strap_done_reg & ~two_wire_reg & ~cs_n;

  // Serial receiver and read shifter
  reg [4:0]  st_reg;
  reg [7:0]  shift_reg;
  reg [3:0]  bit_cnt_reg;
  reg [6:0]  addr_reg;
  reg        rd_mode_reg;
  reg [10:0] wr_word_reg;
  reg        wr_valid_reg;
  wire       fifo_wr_ready;
  wire [7:0] shift_next = {shift_reg[6:0], din};

  always @(posedge clk_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      st_reg         <= ST_ID;
      shift_reg      <= 8'h00;
      bit_cnt_reg    <= 4'h0;
      addr_reg       <= 7'h00;
      rd_mode_reg    <= 1'b0;
      wr_word_reg    <= 11'h000;
      wr_valid_reg   <= 1'b0;
      data_out       <= 1'b0;
      data_oe_out    <= 1'b0;
      bright_reg     <= 4'hF;
      clock_mode_out <= RESET_MODE;
    end
    else
    begin
      if (wr_valid_reg && fifo_wr_ready)
        wr_valid_reg <= 1'b0;
      if (!serial_en)
      begin
        // Interface held in reset while deselected
        st_reg      <= ST_ID;
        shift_reg   <= 8'h00;
        bit_cnt_reg <= 4'h0;
        rd_mode_reg <= 1'b0;
        data_oe_out <= 1'b0;
        data_out    <= 1'b0;
      end
      else if (rd_fall && (st_reg == ST_RDATA))
      begin
        // Next bit goes out on the fall, host takes it on the rise
        data_out    <= ram[addr_reg][3 - bit_cnt_reg[1:0]];
        data_oe_out <= 1'b1;
        bit_cnt_reg <= {2'b00, bit_cnt_reg[1:0] + 2'h1};
        if (bit_cnt_reg[1:0] == 2'h3)
          addr_reg <= lmx_next_addr(addr_reg);
      end
      else if (wr_rise && (st_reg != ST_RDATA))
      begin
        shift_reg   <= shift_next;
        bit_cnt_reg <= bit_cnt_reg + 4'h1;
        case (st_reg)
          ST_ID:
            if (bit_cnt_reg == 4'h2)
            begin
              bit_cnt_reg <= 4'h0;
              if (shift_next[2:0] == `LMX_ID_CMD)
                st_reg <= ST_CMD;
              else if (shift_next[2:0] == `LMX_ID_WRITE)
                st_reg <= ST_ADDR;
              else if (shift_next[2:0] == `LMX_ID_READ)
              begin
                st_reg      <= ST_ADDR;
                rd_mode_reg <= 1'b1;
              end
            end
          ST_CMD:
            if (bit_cnt_reg == 4'h7)
            begin
              bit_cnt_reg <= 4'h0;
              if (shift_next == `LMX_CMD_FOLLOW)
                clock_mode_out <= MODE_FOLLOW;
              else if (shift_next == `LMX_CMD_INT_LEAD)
                clock_mode_out <= MODE_INT_LEAD;
              else if (shift_next == `LMX_CMD_EXT_LEAD)
                clock_mode_out <= MODE_EXT_LEAD;
              else if (shift_next[7:4] == `LMX_CMD_BRIGHT)
                bright_reg <= shift_next[3:0];
            end
          ST_ADDR:
            if (bit_cnt_reg == 4'h6)
            begin
              bit_cnt_reg <= 4'h0;
              addr_reg    <= shift_next[6:0];
              st_reg      <= rd_mode_reg ? ST_RDATA : ST_WDATA;
            end
          ST_WDATA:
            if (bit_cnt_reg == 4'h3)
            begin
              // A nibble waits here until the buffer accepts it
              bit_cnt_reg  <= 4'h0;
              wr_word_reg  <= {addr_reg, shift_next[3:0]};
              wr_valid_reg <= 1'b1;
              addr_reg     <= lmx_next_addr(addr_reg);
            end
          default:
            st_reg <= ST_ID;
        endcase
      end
    end
  end

  // Oscillator divider and system tick selection
  reg [8:0] rc_cnt_reg;
  reg       rc_clk_reg;
  reg       sys_tick_reg;
  wire      rc_wrap = (rc_cnt_reg == `LMX_RC_HALF_CYC - 1);
  wire      int_mode = (clock_mode_out == MODE_INT_LEAD);
  always @(posedge clk_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      rc_cnt_reg   <= 9'h000;
      rc_clk_reg   <= 1'b0;
      sys_tick_reg <= 1'b0;
      osc_out      <= 1'b0;
      osc_oe_out   <= 1'b0;
    end
    else
    begin
      rc_cnt_reg <= rc_wrap ? 9'h000 : rc_cnt_reg + 9'h001;
      if (rc_wrap)
        rc_clk_reg <= ~rc_clk_reg;
      sys_tick_reg <= int_mode ? (rc_wrap & ~rc_clk_reg) : osc_rise;
      osc_out      <= int_mode & rc_clk_reg;
      osc_oe_out   <= int_mode;
    end
  end

  // Scan counters, frame sync and PWM row drive
  reg  [8:0] slot_cnt_reg;
  reg  [2:0] com_reg;
  wire       follow = (clock_mode_out == MODE_FOLLOW);
  wire [8:0] lit_ticks = {1'b0, bright_reg, 4'h0} + {3'b000, bright_reg, 2'b00} + 9'd20;
  integer    r;
  always @(posedge clk_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      slot_cnt_reg            <= 9'h000;
      com_reg                 <= 3'h0;
      sync_out                <= 1'b0;
      sync_oe_out             <= 1'b0;
      shared_scan_lines_out   <= 8'h00;
      segment_drive_lines_out <= 44'h000_0000_0000;
    end
    else
    begin
      if (follow && sync_rise)
      begin
        // Leader frame start realigns this device
        slot_cnt_reg <= 9'h000;
        com_reg      <= 3'h0;
      end
      else if (sys_tick_reg)
      begin
        if (slot_cnt_reg == `LMX_SLOT_TICKS - 1)
        begin
          slot_cnt_reg <= 9'h000;
          com_reg      <= com_reg + 3'h1;
        end
        else
          slot_cnt_reg <= slot_cnt_reg + 9'h001;
      end
      sync_oe_out <= ~follow;
      sync_out    <= ~follow & (com_reg == 3'h0);
      shared_scan_lines_out <= 8'h01 << com_reg;
      for (r = 0; r < `LMX_ROWS; r = r + 1)
        segment_drive_lines_out[r] <= (slot_cnt_reg < lit_ticks) &
                                      ram[r * 2 + com_reg[2]][com_reg[1:0]];
    end
  end

  // Buffer between serial writes and the RAM; drain pauses on scan ticks
  wire [10:0] fifo_rd_data;
  wire        fifo_rd_valid;
  wire        fifo_rd_ready = ~sys_tick_reg;
  lmx_fifo #(
    .WIDTH (11),
    .DEPTH (`LMX_FIFO_DEPTH),
    .AW    (4)
  ) u_fifo (
    .clk_in       (clk_in),
    .nrst_in      (nrst_in),
    .flush_in     (1'b0),
    .wr_data_in   (wr_word_reg),
    .wr_valid_in  (wr_valid_reg),
    .wr_ready_out (fifo_wr_ready),
    .rd_data_out  (fifo_rd_data),
    .rd_valid_out (fifo_rd_valid),
    .rd_ready_in  (fifo_rd_ready)
  );

  // RAM write port; addresses past the end are dropped
  integer i;
  always @(posedge clk_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      for (i = 0; i < `LMX_RAM_WORDS; i = i + 1)
        ram[i] <= 4'h0;
    end
    else if (fifo_rd_valid && fifo_rd_ready &&
             (fifo_rd_data[10:4] < `LMX_RAM_WORDS))
      ram[fifo_rd_data[10:4]] <= fifo_rd_data[3:0];
  end
endmodule
`default_nettype wire

/* verif/lmx_core_checker.sv */
`timescale 1ns/1ps
`default_nettype none
module lmx_core_checker (
  input wire logic       clk_in,
  input wire logic       nrst_in,
  input wire logic       two_wire_variant_in,
  input wire logic       chip_select_n_in,
  input wire logic       read_strobe_clock_in,
  input wire logic       data_out,
  input wire logic       data_oe_out,
  input wire logic       osc_oe_out,
  input wire logic       sync_oe_out,
  input wire logic [1:0] bus_addr_out,
  input wire logic [2:0] clock_mode_out,
  input wire logic [7:0] shared_scan_lines_out
);
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!nrst_in);
  // Pin directions may lag a mode change by a cycle
  sequence mode_held;
    $stable(clock_mode_out) [*3];
  endsequence
  // Two sync flops plus a register before the interface clears
  sequence deselected;
    chip_select_n_in [*6];
  endsequence
  // Mode and pin directions
  mode_onehot_a: assert property ($onehot(clock_mode_out))
    else $error("clock mode not one-hot");
  osc_dir_a: assert property (mode_held |-> osc_oe_out == clock_mode_out[1])
    else $error("clock pin direction wrong");
  sync_dir_a: assert property (mode_held |-> sync_oe_out == !clock_mode_out[0])
    else $error("sync pin direction wrong");
  // Serial link
  cs_refuse_a: assert property (deselected |-> !data_oe_out)
    else $error("data driven while deselected");
  oe_in_frame_a: assert property ($rose(data_oe_out) |-> !$past(chip_select_n_in, 3))
    else $error("data driven outside a frame");
  // Clearing on deselect also moves the bit, so only a driven line counts
  bit_on_fall_a: assert property ($changed(data_out) && data_oe_out |-> !$past(read_strobe_clock_in, 3))
    else $error("read bit moved without strobe fall");
  four_wire_addr_a: assert property (!two_wire_variant_in [*2] |-> bus_addr_out == 2'h0)
    else $error("address pins reported in four-wire mode");
  scan_onehot_a: assert property ($past(nrst_in, 2) |-> $onehot(shared_scan_lines_out))
    else $error("common lines not one-hot");
endmodule
bind lmx_core lmx_core_checker i_lmx_core_checker (.clk_in(clk_in), .nrst_in(nrst_in),
  .two_wire_variant_in(two_wire_variant_in), .chip_select_n_in(chip_select_n_in),
  .read_strobe_clock_in(read_strobe_clock_in), .data_out(data_out),
  .data_oe_out(data_oe_out), .osc_oe_out(osc_oe_out), .sync_oe_out(sync_oe_out),
  .bus_addr_out(bus_addr_out), .clock_mode_out(clock_mode_out),
  .shared_scan_lines_out(shared_scan_lines_out));
`default_nettype wire

/* verif/lmx_host_model.sv */
`timescale 1ns/1ps
`default_nettype none
module lmx_host_model (
  input  wire logic clk_in,
  input  wire logic dev_bit_in,
  input  wire logic dev_oe_in,
  output wire logic cs_n_out,
  output wire logic wr_out,
  output wire logic rd_out,
  output wire logic line_out
);
  logic link_clk = 1'b0;
  logic cs_reg   = 1'b1;
  logic wr_reg   = 1'b1;
  logic rd_reg   = 1'b1;
  logic drv_reg  = 1'b0;
  logic bit_reg  = 1'b1;
  // Link timing reference, unrelated in phase to the core clock
  always #32 link_clk = ~link_clk;
  // Strobes and select idle high; a released line floats to its pull-up
  assign cs_n_out = cs_reg;
  assign wr_out   = wr_reg;
  assign rd_out   = rd_reg;
  assign line_out = dev_oe_in ? dev_bit_in : (drv_reg ? bit_reg : 1'b1);
  // Several link half periods, ending just on a core edge; slows strobes to their limits
  task automatic step(input int n);
    repeat (n) @(link_clk);
    @(posedge clk_in);
  endtask
  // Frame boundaries
  task automatic open_frame();
    step(16);
    cs_reg <= 1'b0;
  endtask
  task automatic close_frame();
    step(16);
    cs_reg  <= 1'b1;
    drv_reg <= 1'b0;
  endtask
  // Data set up while the strobe is low, held well past its rise
  task automatic wr_bit(input logic b);
    step(16);
    wr_reg  <= 1'b0;
    drv_reg <= 1'b1;
    bit_reg <= b;
    step(16);
    wr_reg <= 1'b1;
  endtask
  // Line released at the fall, bit taken as the strobe rises again
  task automatic rd_bit(output logic b);
    step(32);
    rd_reg  <= 1'b0;
    drv_reg <= 1'b0;
    step(32);
    b = line_out;
    rd_reg <= 1'b1;
  endtask
endmodule
`default_nettype wire

/* verif/lmx_core_bench.sv */
`timescale 1ns/1ps
`default_nettype none
`include "lmx_map.vh"
module lmx_core_bench;
  logic       clk_in;
  logic       nrst_in;
  wire        cs_n, wr, rd, line, d_out, d_oe, osc_oe, sync_oe, o_out, s_out;
  wire  [7:0] scan;
  wire  [2:0] mode;
  int         err_total;
  int         samples_checked;
  // Design with its strap, clock pin and sync pin held quiet
  lmx_core i_lmx_core (.clk_in(clk_in), .nrst_in(nrst_in), .two_wire_variant_in(1'b0),
    .chip_select_n_in(cs_n), .write_strobe_clock_in(wr), .read_strobe_clock_in(rd),
    .data_in(line), .data_out(d_out), .data_oe_out(d_oe), .osc_in(1'b0), .osc_out(o_out),
    .osc_oe_out(osc_oe), .sync_in(1'b0), .sync_out(s_out), .sync_oe_out(sync_oe),
    .bus_addr_out(), .clock_mode_out(mode), .shared_scan_lines_out(scan),
    .segment_drive_lines_out());
  lmx_host_model i_lmx_host_model (.clk_in(clk_in), .dev_bit_in(d_out), .dev_oe_in(d_oe),
    .cs_n_out(cs_n), .wr_out(wr), .rd_out(rd), .line_out(line));
  // 200 MHz core clock
  initial
  begin
    clk_in = 1'b0;
    forever #2.5 clk_in = ~clk_in;
  end
  task automatic complete_run();
    if (err_total == 0 && samples_checked > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    samples_checked++;
    if (got !== exp)
    begin
      err_total++;
      $display("[ERR] %s exp %h got %h", what, exp, got);
    end
  endtask
  // Frames; sel low shifts the same bits with the chip left deselected
  task automatic cmd(input logic [7:0] c, input logic sel);
    logic [10:0] v;
    v = {`LMX_ID_CMD, c};
    if (sel) i_lmx_host_model.open_frame();
    for (int i = 10; i >= 0; i--) i_lmx_host_model.wr_bit(v[i]);
    i_lmx_host_model.close_frame();
  endtask
  task automatic wr_word(input logic [6:0] a, input logic [7:0] d, input logic sel);
    logic [17:0] v;
    v = {`LMX_ID_WRITE, a, d};
    if (sel) i_lmx_host_model.open_frame();
    for (int i = 17; i >= 0; i--) i_lmx_host_model.wr_bit(v[i]);
    i_lmx_host_model.close_frame();
  endtask
  task automatic rd_word(input logic [6:0] a, output logic [7:0] d);
    logic [9:0] v;
    v = {`LMX_ID_READ, a};
    i_lmx_host_model.open_frame();
    for (int i = 9; i >= 0; i--) i_lmx_host_model.wr_bit(v[i]);
    for (int i = 7; i >= 0; i--) i_lmx_host_model.rd_bit(d[i]);
    i_lmx_host_model.close_frame();
  endtask
  // Lead mode with internal oscillator straight out of reset
  task automatic t_reset();
    chk("reset mode pins", 8'h0B, {mode, osc_oe, sync_oe});
    chk("reset sync out", 8'h01, {7'h00, s_out});
    chk("reset commons", 8'h01, scan);
  endtask
  // Internal lead drives the divided oscillator out; one period in core clocks
  task automatic t_osc();
    time t0;
    @(posedge o_out);
    t0 = $time;
    @(posedge o_out);
    chk("osc period", 2 * `LMX_RC_HALF_CYC, ($time - t0) / 5);
  endtask
  // Every mode command; pins may settle a few cycles after the code
  task automatic t_modes();
    logic [7:0] code [3] = '{`LMX_CMD_FOLLOW, `LMX_CMD_EXT_LEAD, `LMX_CMD_INT_LEAD};
    logic [4:0] exp  [3] = '{5'h04, 5'h11, 5'h0B};
    for (int k = 0; k < 3; k++)
    begin
      cmd(code[k], 1'b1);
      repeat (64) if ({mode, osc_oe, sync_oe} !== exp[k]) @(negedge clk_in);
      chk("mode pins", exp[k], {mode, osc_oe, sync_oe});
    end
  endtask
  // Last word wraps to word 0; read back crosses the same boundary
  task automatic t_ram();
    logic [7:0] d;
    wr_word(7'h57, 8'hA5, 1'b1);
    rd_word(7'h57, d);
    chk("ram wrap", 8'hA5, d);
    wr_word(7'h28, 8'h96, 1'b1);
    rd_word(7'h28, d);
    chk("ram mid", 8'h96, d);
  endtask
  // Traffic with the chip deselected must leave mode and RAM alone
  task automatic t_refuse();
    logic [7:0] d;
    cmd(`LMX_CMD_FOLLOW, 1'b0);
    wr_word(7'h57, 8'h00, 1'b0);
    chk("mode kept", 8'h02, {5'h00, mode});
    rd_word(7'h57, d);
    chk("ram kept", 8'hA5, d);
  endtask
  // Main sequence
  initial
  begin
    err_total = 0;
    samples_checked = 0;
    nrst_in = 1'b0;
    repeat (8) @(posedge clk_in);
    nrst_in <= 1'b1;
    repeat (4) @(posedge clk_in);
    @(negedge clk_in);
    t_reset();
    t_modes();
    t_osc();
    t_ram();
    t_refuse();
    complete_run();
  end
  // Watchdog: the frames need roughly two thirds of this span
  initial
  begin
    #300000;
    err_total++;
    complete_run();
  end
endmodule
`default_nettype wire
